// file: verilog/acrp_top.sv
`include "acrp_regs.svh"

module acrp_top (
    input  wire logic                 i_clk,
    input  wire logic                 i_srst,
    input  wire logic                 i_reset_pin,
    input  wire logic                 i_start_input_group_one,
    input  wire logic                 i_start_input_group_two,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_read_strobe_n,
    input  wire logic                 i_interface_select,
    input  wire logic                 i_byte_mode_select,
    input  wire logic                 i_high_byte_first,
    input  wire acrp_pkg::acrp_bank_t i_chan_data,
    output logic                      o_busy,
    output logic [15:0]               o_parallel_result_bus,
    output logic [15:0]               o_parallel_result_bus_oe,
    output logic                      o_first_channel_marker,
    output logic                      o_first_channel_marker_oe
);
    import acrp_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] pin_raw, sync1_r, sync2_r, prev_r;
    assign pin_raw = {i_reset_pin, i_start_input_group_one, i_start_input_group_two, i_cs_n,
                      i_read_strobe_n, i_interface_select, i_byte_mode_select, i_high_byte_first};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sync
            // Reset to the pin's idle level, so no false select or strobe edge
            localparam logic idle = 1'(`ACRP_SYNC_IDLE >> g);
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    sync1_r[g] <= idle;
                    sync2_r[g] <= idle;
                    prev_r[g]  <= idle;
                end else begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                    prev_r[g]  <= sync2_r[g];
                end
            end
        end
    endgenerate

    logic rst_s, cs_s, rd_s, if_s, bs_s, hbf_s;
    logic rst_pin_rise, cs_fall, rd_fall, rd_rise, ser_mode, byte_mode;
    assign rst_s     = sync2_r[7];
    assign cs_s      = sync2_r[4];
    assign rd_s      = sync2_r[3];
    assign if_s      = sync2_r[2];
    assign bs_s      = sync2_r[1];
    assign hbf_s     = sync2_r[0];
    assign cs_fall   = prev_r[4] & ~cs_s;
    assign rd_fall   = prev_r[3] & ~rd_s;
    assign rd_rise   = ~prev_r[3] & rd_s;
    assign rst_pin_rise = rst_s & ~prev_r[7];
    assign ser_mode  = if_s & ~bs_s;
    assign byte_mode = if_s & bs_s;

    // ****************************************
    // Conversion engine
    // ****************************************
    acrp_res_if res_if ();
    assign res_if.abort = rst_pin_rise;

    acrp_conv acrp_conv_inst (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_start_one (sync2_r[6]),
        .i_start_two (sync2_r[5]),
        .i_chan_data (i_chan_data),
        .res         (res_if.conv)
    );

    // output one carries channels 1-4, output two 5-8
    function automatic logic [15:0] ser_bits(input acrp_bank_t bank, input logic [1:0] ch, input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        v[`ACRP_SER_ONE_BIT] = bank[{1'h0, ch}][idx];
        v[`ACRP_SER_TWO_BIT] = bank[{1'h1, ch}][idx];
        return v;
    endfunction : ser_bits

    // High byte carries sign copies above bit 13
    function automatic logic [7:0] byte_of(input acrp_word_t w, input logic hi);
        return hi ? {w[13], w[13], w[13:8]} : w[7:0];
    endfunction : byte_of

    // ****************************************
    // Readout
    // ****************************************
    acrp_bank_t  bank;
    acrp_word_t  cur;
    logic [2:0]  ch_r, ch_nxt;
    logic [3:0]  pos_r, pos_nxt;
    logic [3:0]  fcnt_r, fcnt_nxt;
    logic        half_r, half_nxt;
    logic [15:0] data_r, data_nxt;
    logic [15:0] oe_r, oe_nxt;
    logic        mark_r, mark_nxt;
    logic        moe_r, moe_nxt;
    logic [15:0] exp_shift;

    assign bank      = res_if.result;
    assign cur       = bank[ch_r];
    assign exp_shift = ser_bits(bank, ch_r[1:0], 4'(`ACRP_SER_MSB_IDX - pos_r));

    always_comb begin
        ch_nxt   = ch_r;
        pos_nxt  = pos_r;
        fcnt_nxt = fcnt_r;
        half_nxt = half_r;
        data_nxt = data_r;
        mark_nxt = mark_r;
        oe_nxt   = 16'h0000;
        moe_nxt  = 1'h0;
        if (rst_pin_rise) begin
            ch_nxt   = 3'h0;
            pos_nxt  = 4'h0;
            fcnt_nxt = 4'h0;
            half_nxt = 1'h0;
            data_nxt = 16'h0000;
            mark_nxt = 1'h0;
        end else if (cs_s) begin
            mark_nxt = 1'h0;
        end else begin
            moe_nxt = 1'h1;
            // drive while selected; serial drives whole frame, parallel and byte only while reading
            if (ser_mode)
                oe_nxt = `ACRP_SER_OE;
            else if (byte_mode)
                oe_nxt = rd_s ? 16'h0000 : `ACRP_BYTE_OE;
            else
                oe_nxt = rd_s ? 16'h0000 : 16'hffff;
            if (cs_fall) begin
                ch_nxt   = 3'h0;
                half_nxt = 1'h0;
                fcnt_nxt = 4'h0;
                pos_nxt  = 4'h1;
                mark_nxt = ser_mode;
                if (ser_mode)
                    data_nxt = ser_bits(bank, 2'h0, `ACRP_SER_MSB_IDX);
            end else if (ser_mode) begin
                if (rd_rise) begin
                    if (pos_r == `ACRP_SER_BITS) begin
                        ch_nxt   = ch_r + 3'h1;
                        pos_nxt  = 4'h1;
                        data_nxt = ser_bits(bank, 2'(ch_r + 3'h1), `ACRP_SER_MSB_IDX);
                    end else begin
                        pos_nxt  = pos_r + 4'h1;
                        data_nxt = exp_shift;
                    end
                end
                // marker low on 14th clock fall
                if (rd_fall && fcnt_r != `ACRP_SER_BITS)
                    fcnt_nxt = fcnt_r + 4'h1;
                if (fcnt_nxt == `ACRP_SER_BITS)
                    mark_nxt = 1'h0;
            end else if (rd_fall) begin
                mark_nxt = (ch_r == 3'h0) && !half_r;
                if (byte_mode) begin
                    data_nxt = {8'h00, byte_of(cur, hbf_s ^ half_r)};
                    half_nxt = ~half_r;
                    if (half_r)
                        ch_nxt = ch_r + 3'h1;
                end else begin
                    // sign copies on 15 and 14
                    data_nxt = {cur[13], cur[13], cur};
                    ch_nxt   = ch_r + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ch_r   <= 3'h0;
            pos_r  <= 4'h0;
            fcnt_r <= 4'h0;
            half_r <= 1'h0;
            data_r <= 16'h0000;
            oe_r   <= 16'h0000;
            mark_r <= 1'h0;
            moe_r  <= 1'h0;
        end else begin
            ch_r   <= ch_nxt;
            pos_r  <= pos_nxt;
            fcnt_r <= fcnt_nxt;
            half_r <= half_nxt;
            data_r <= data_nxt;
            oe_r   <= oe_nxt;
            mark_r <= mark_nxt;
            moe_r  <= moe_nxt;
        end
    end

    assign o_busy                    = res_if.busy;
    assign o_parallel_result_bus     = data_r;
    assign o_parallel_result_bus_oe  = oe_r;
    assign o_first_channel_marker    = mark_r;
    assign o_first_channel_marker_oe = moe_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_ser_active;
        ser_mode && !cs_s && !cs_fall && !rst_pin_rise;
    endsequence

    AST_PAR_OE: assert property (!if_s && !cs_s && !rd_s && !rst_pin_rise |=> oe_r == 16'hffff)
        else $error("parallel bus not driven during read");
    AST_DESEL_Z: assert property (cs_s |=> oe_r == 16'h0000 && !moe_r)
        else $error("outputs driven while deselected");
    AST_SER_MSB: assert property (ser_mode && cs_fall && !rst_pin_rise
        |=> oe_r == `ACRP_SER_OE && mark_r && data_r[7] == $past(bank[0][13]) && data_r[8] == $past(bank[4][13]))
        else $error("serial MSB not presented at frame start");
    AST_SER_SHIFT: assert property (s_ser_active ##0 (rd_rise && pos_r != `ACRP_SER_BITS)
        |=> data_r == $past(exp_shift))
        else $error("serial bit not shifted on clock rise");
    AST_MARK_SER: assert property (s_ser_active ##0 (rd_fall && fcnt_r == 4'hd) |=> !mark_r)
        else $error("serial marker not lowered on 14th fall");
    sequence s_par_read;
        !ser_mode && !cs_s && !cs_fall && !rst_pin_rise && rd_fall;
    endsequence

    AST_MARK_PAR: assert property (s_par_read ##0 (ch_r == 3'h0 && !half_r) |=> mark_r)
        else $error("marker not raised on channel one read");
    AST_MARK_PAR_LOW: assert property (s_par_read ##0 (ch_r != 3'h0 || half_r) |=> !mark_r)
        else $error("marker not lowered on next read");
    AST_SIGN: assert property (!if_s && !cs_s && !cs_fall && !rst_pin_rise && rd_fall
        |=> data_r[15:14] == {2{data_r[13]}} && data_r[13:0] == $past(cur))
        else $error("word mode sign copies wrong");
    AST_CLEAR: assert property (rst_pin_rise |=> data_r == 16'h0000 && !mark_r && ch_r == 3'h0)
        else $error("reset pulse did not clear outputs");
endmodule : acrp_top

// file: inc/acrp_regs.svh
`ifndef ACRP_REGS_SVH
`define ACRP_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define ACRP_CLK_PERIOD_NS  40
`define ACRP_CONV_TIME_NS   4000
`define ACRP_CONV_CYCLES    ((`ACRP_CONV_TIME_NS + `ACRP_CLK_PERIOD_NS - 1) / `ACRP_CLK_PERIOD_NS)
`define ACRP_HOST_RESET_NS  50

// ****************************************
// Result and serial layout
// ****************************************
`define ACRP_SER_BITS       4'he
`define ACRP_SER_MSB_IDX    4'hd
`define ACRP_SER_ONE_BIT    7
`define ACRP_SER_TWO_BIT    8
`define ACRP_SER_OE         16'h0180
`define ACRP_BYTE_OE        16'h00ff
`define ACRP_RESULT_RESET   14'h0000
`define ACRP_SYNC_IDLE      8'h18

`endif

// file: inc/acrp_pkg.sv
package acrp_pkg;
    typedef logic [13:0]      acrp_word_t;
    typedef acrp_word_t [7:0] acrp_bank_t;
    typedef enum logic [1:0] {
        ACRP_CV_IDLE = 2'h1,
        ACRP_CV_BUSY = 2'h2
    } acrp_cv_state_t;
endpackage : acrp_pkg

// file: inc/acrp_res_if.sv
interface acrp_res_if;
    import acrp_pkg::*;
    logic       abort;
    logic       busy;
    acrp_bank_t result;
    modport conv (input abort, output busy, output result);
    modport rd   (output abort, input busy, input result);
endinterface : acrp_res_if

// file: verilog/acrp_conv.sv
`include "acrp_regs.svh"

module acrp_conv (
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    input  wire logic                i_start_one,
    input  wire logic                i_start_two,
    input  wire acrp_pkg::acrp_bank_t i_chan_data,
    acrp_res_if.conv                 res
);
    import acrp_pkg::*;

    acrp_cv_state_t st_r, st_nxt;
    logic [6:0]     cnt_r, cnt_nxt;
    logic           one_prev_r, two_prev_r;
    logic           one_seen_r, one_seen_nxt;
    logic           two_seen_r, two_seen_nxt;
    logic           busy_r, busy_nxt;
    acrp_bank_t     res_r, res_nxt;
    logic           rise_one, rise_two;

    assign rise_one   = i_start_one & ~one_prev_r;
    assign rise_two   = i_start_two & ~two_prev_r;
    assign res.busy   = busy_r;
    assign res.result = res_r;

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_comb begin
        st_nxt       = st_r;
        cnt_nxt      = cnt_r;
        one_seen_nxt = one_seen_r;
        two_seen_nxt = two_seen_r;
        busy_nxt     = busy_r;
        res_nxt      = res_r;
        case (st_r)
            ACRP_CV_IDLE: begin
                one_seen_nxt = one_seen_r | rise_one;
                two_seen_nxt = two_seen_r | rise_two;
                if (one_seen_nxt && two_seen_nxt) begin
                    st_nxt       = ACRP_CV_BUSY;
                    busy_nxt     = 1'h1;
                    cnt_nxt      = 7'h00;
                    one_seen_nxt = 1'h0;
                    two_seen_nxt = 1'h0;
                end
            end
            ACRP_CV_BUSY: begin
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == 7'(`ACRP_CONV_CYCLES - 1)) begin
                    st_nxt   = ACRP_CV_IDLE;
                    busy_nxt = 1'h0;
                    res_nxt  = i_chan_data;
                end
            end
            default: begin
                st_nxt   = ACRP_CV_IDLE;
                busy_nxt = 1'h0;
            end
        endcase
        if (res.abort) begin
            st_nxt       = ACRP_CV_IDLE;
            busy_nxt     = 1'h0;
            cnt_nxt      = 7'h00;
            one_seen_nxt = 1'h0;
            two_seen_nxt = 1'h0;
            res_nxt      = {8{`ACRP_RESULT_RESET}};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r       <= ACRP_CV_IDLE;
            cnt_r      <= 7'h00;
            one_prev_r <= 1'h0;
            two_prev_r <= 1'h0;
            one_seen_r <= 1'h0;
            two_seen_r <= 1'h0;
            busy_r     <= 1'h0;
            res_r      <= {8{`ACRP_RESULT_RESET}};
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            one_prev_r <= i_start_one;
            two_prev_r <= i_start_two;
            one_seen_r <= one_seen_nxt;
            two_seen_r <= two_seen_nxt;
            busy_r     <= busy_nxt;
            res_r      <= res_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_both_edges;
        st_r == ACRP_CV_IDLE && (one_seen_r || rise_one) && (two_seen_r || rise_two) && !res.abort;
    endsequence

    AST_BUSY_RISE: assert property (s_both_edges |=> busy_r)
        else $error("busy did not rise after both starts");
    AST_START_IGNORED: assert property (busy_r |=> !one_seen_r && !two_seen_r)
        else $error("start edge recorded while busy");
    AST_BUSY_HOLD: assert property (busy_r && !res.abort && cnt_r != 7'(`ACRP_CONV_CYCLES - 1)
        |=> busy_r && cnt_r == $past(cnt_r) + 7'h01)
        else $error("busy dropped before conversion end");
    AST_LATCH: assert property ($fell(busy_r) && !$past(res.abort) |-> res_r == $past(i_chan_data))
        else $error("results not latched on busy fall");
    AST_ABORT: assert property (res.abort |=> !busy_r && res_r == '0)
        else $error("reset pulse did not abort");
endmodule : acrp_conv

// file: verif/acrp_host_model.sv
module acrp_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_bus,
    input  wire logic [15:0] i_bus_oe,
    input  wire logic        i_marker,
    input  wire logic        i_marker_oe,
    output logic             o_cs_n,
    output logic             o_rd_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Captured answers
    // ****************************************
    logic [15:0] got_data;
    logic [15:0] got_oe;
    logic [15:0] got_idle_oe;
    logic        got_mark;
    logic        got_moe;
    logic        mk_first;
    logic        mk_late;
    logic [13:0] ser_one [0:3];
    logic [13:0] ser_two [0:3];
    logic [15:0] seen;

    // Undriven lines read back inverted, so a float never passes
    assign seen = i_bus ^ ~i_bus_oe;

    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
    end

    task automatic settle(input int n);
        repeat (n) @(negedge i_clk);
    endtask : settle

    // ****************************************
    // Parallel and byte access
    // ****************************************
    // reads never overlap busy
    task automatic frame_open();
        @(negedge i_clk);
        o_cs_n = 1'b0;
        settle(6);
        got_moe = i_marker_oe;
    endtask : frame_open

    task automatic frame_close();
        @(negedge i_clk);
        o_cs_n = 1'b1;
        settle(6);
        got_moe = i_marker_oe;
    endtask : frame_close

    // Pins lag three clocks, so sample five later
    task automatic strobe();
        @(negedge i_clk);
        o_rd_n = 1'b0;
        settle(5);
        got_data = seen;
        got_oe   = i_bus_oe;
        got_mark = i_marker;
        o_rd_n   = 1'b1;
        settle(5);
        got_idle_oe = i_bus_oe;
    endtask : strobe

    // ****************************************
    // Serial access
    // ****************************************
    // strobe is serial clock
    // Clock idles high and stands still outside frames; 320 ns period
    task automatic serial_frame();
        @(negedge i_clk);
        o_cs_n = 1'b0;
        settle(4);
        got_oe = i_bus_oe;
        for (int j = 0; j < 56; j++) begin
            ser_one[j / 14][13 - (j % 14)] = seen[7];
            ser_two[j / 14][13 - (j % 14)] = seen[8];
            if (j == 0) mk_first = i_marker;
            if (j == 14) mk_late = i_marker;
            if (j < 55) begin
                o_rd_n = 1'b0;
                settle(4);
                o_rd_n = 1'b1;
                settle(4);
            end
        end
        o_cs_n = 1'b1;
        settle(6);
    endtask : serial_frame
endmodule : acrp_host_model

// file: verif/adc_conversion_readout_port_tb.sv
module adc_conversion_readout_port_tb;
    import acrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk  = 1'b0;
    logic        srst = 1'b1;
    logic        rpin = 1'b0;
    logic        st1  = 1'b0;
    logic        st2  = 1'b0;
    logic        isel = 1'b0;
    logic        bsel = 1'b0;
    logic        hbf  = 1'b0;
    logic        cs_n;
    logic        rd_n;
    logic        busy;
    logic        mark;
    logic        moe;
    logic [15:0] bus;
    logic [15:0] bus_oe;
    logic [13:0] w [0:7];
    logic [7:0]  hi;
    logic [7:0]  lo;
    acrp_bank_t  chan;
    int          bad_count = 0;
    int          checks    = 0;
    int          n;

    always #20 clk = ~clk;

    acrp_top acrp_top_inst (
        .i_clk                     (clk),
        .i_srst                    (srst),
        .i_reset_pin               (rpin),
        .i_start_input_group_one   (st1),
        .i_start_input_group_two   (st2),
        .i_cs_n                    (cs_n),
        .i_read_strobe_n           (rd_n),
        .i_interface_select        (isel),
        .i_byte_mode_select        (bsel),
        .i_high_byte_first         (hbf),
        .i_chan_data               (chan),
        .o_busy                    (busy),
        .o_parallel_result_bus     (bus),
        .o_parallel_result_bus_oe  (bus_oe),
        .o_first_channel_marker    (mark),
        .o_first_channel_marker_oe (moe)
    );

    acrp_host_model acrp_host_model_inst (
        .i_clk       (clk),
        .i_bus       (bus),
        .i_bus_oe    (bus_oe),
        .i_marker    (mark),
        .i_marker_oe (moe),
        .o_cs_n      (cs_n),
        .o_rd_n      (rd_n)
    );

    // ****************************************
    // Compare and control tasks
    // ****************************************
    task automatic end_sim();
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic wait_busy(input logic v);
        for (int i = 0; i < 20; i++) begin
            if (busy === v) return;
            @(negedge clk);
        end
        bad_count++;
        $display("unexpected at %0t: busy wait timed out", $time);
        end_sim();
    endtask : wait_busy

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        for (int k = 0; k < 8; k++) begin
            w[k]    = 14'(14'h0a35 + 14'h0711 * k) ^ ((k % 2) ? 14'h2000 : 14'h0000);
            chan[k] = w[k];
        end
        repeat (4) @(negedge clk);
        srst = 1'b0;
        rpin = 1'b1;
        repeat (3) @(negedge clk);
        rpin = 1'b0;
        repeat (5) @(negedge clk);
        st1 = 1'b1;
        repeat (10) @(negedge clk);
        chk_bit(busy, 1'b0, "busy on one start");
        st2 = 1'b1;
        wait_busy(1'b1);
        repeat (3) @(negedge clk);
        st1 = 1'b0;
        st2 = 1'b0;
        repeat (5) @(negedge clk);
        // Starts raised again mid-conversion must be dropped
        st1 = 1'b1;
        st2 = 1'b1;
        n = 8;
        for (int i = 0; i < 200 && busy === 1'b1; i++) begin
            @(negedge clk);
            n++;
        end
        chk_word(16'(n), 16'h0064, "busy length");
        repeat (20) @(negedge clk);
        chk_bit(busy, 1'b0, "ignored start");
        st1 = 1'b0;
        st2 = 1'b0;
        acrp_host_model_inst.frame_open();
        chk_bit(acrp_host_model_inst.got_moe, 1'b1, "marker oe at frame");
        for (int k = 0; k < 8; k++) begin
            acrp_host_model_inst.strobe();
            chk_word(acrp_host_model_inst.got_data, {w[k][13], w[k][13], w[k]}, "word");
            chk_word(acrp_host_model_inst.got_oe, 16'hffff, "word oe");
            chk_word(acrp_host_model_inst.got_idle_oe, 16'h0000, "idle oe");
            chk_bit(acrp_host_model_inst.got_mark, k == 0, "word marker");
        end
        acrp_host_model_inst.frame_close();
        chk_bit(acrp_host_model_inst.got_moe, 1'b0, "marker oe idle");
        isel = 1'b1;
        bsel = 1'b1;
        for (int h = 0; h < 2; h++) begin
            hbf = h[0];
            acrp_host_model_inst.frame_open();
            for (int k = 0; k < 16; k++) begin
                acrp_host_model_inst.strobe();
                hi = {w[k / 2][13], w[k / 2][13], w[k / 2][13:8]};
                lo = w[k / 2][7:0];
                chk_word({8'h00, acrp_host_model_inst.got_data[7:0]},
                         {8'h00, ((k % 2 == 0) == (h == 1)) ? hi : lo}, "byte");
                chk_word(acrp_host_model_inst.got_oe, 16'h00ff, "byte oe");
                chk_bit(acrp_host_model_inst.got_mark, k == 0, "byte marker");
            end
            acrp_host_model_inst.frame_close();
        end
        bsel = 1'b0;
        acrp_host_model_inst.serial_frame();
        chk_word(acrp_host_model_inst.got_oe, 16'h0180, "serial oe");
        chk_bit(acrp_host_model_inst.mk_first, 1'b1, "serial marker up");
        chk_bit(acrp_host_model_inst.mk_late, 1'b0, "serial marker down");
        for (int k = 0; k < 4; k++) begin
            chk_word({2'b00, acrp_host_model_inst.ser_one[k]}, {2'b00, w[k]}, "serial one");
            chk_word({2'b00, acrp_host_model_inst.ser_two[k]}, {2'b00, w[k + 4]}, "serial two");
        end
        // Reset pin mid-conversion: abort, and old results must be gone
        isel = 1'b0;
        st1 = 1'b1;
        st2 = 1'b1;
        wait_busy(1'b1);
        repeat (20) @(negedge clk);
        st1 = 1'b0;
        st2 = 1'b0;
        rpin = 1'b1;
        repeat (3) @(negedge clk);
        rpin = 1'b0;
        wait_busy(1'b0);
        repeat (100) @(negedge clk);
        chk_bit(busy, 1'b0, "busy after abort");
        acrp_host_model_inst.frame_open();
        acrp_host_model_inst.strobe();
        chk_word(acrp_host_model_inst.got_data, 16'h0000, "cleared result");
        acrp_host_model_inst.frame_close();
        end_sim();
    end
endmodule : adc_conversion_readout_port_tb
